//--- rtl/sfp_pkg.sv
package sfp_pkg;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_QPP  = 8'h32;
  localparam logic [7:0] OP_SE   = 8'h20;
  localparam logic [7:0] OP_B32  = 8'h52;
  localparam logic [7:0] OP_B64  = 8'hd8;
  localparam logic [7:0] OP_CE1  = 8'hc7;
  localparam logic [7:0] OP_CE2  = 8'h60;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RES  = 8'h7a;
  localparam logic [7:0] OP_PD   = 8'hb9;
  localparam logic [7:0] OP_RPD  = 8'hab;
  // ------------------------------------------------------------
  // framing and geometry
  // ------------------------------------------------------------
  localparam logic [2:0]  HDR_BYTES = 3'h4;
  localparam logic [2:0]  DATA_MIN  = 3'h5;
  localparam logic [2:0]  ONE_BYTE  = 3'h1;
  localparam logic [8:0]  LEN_MAX   = 9'h100;
  localparam int          PAGE_BYTES = 256;
  localparam logic [23:0] MASK_SE   = 24'h000fff;
  localparam logic [23:0] MASK_B32  = 24'h007fff;
  localparam logic [23:0] MASK_B64  = 24'h00ffff;
  localparam logic [23:0] MASK_PP   = 24'h0000ff;
  // ------------------------------------------------------------
  // timing, nanoseconds
  // ------------------------------------------------------------
  localparam int CLK_NS    = 4;
  localparam int T_PP_NS   = 400000;
  localparam int T_SE_NS   = 45000000;
  localparam int T_B32_NS  = 120000000;
  localparam int T_B64_NS  = 150000000;
  localparam int T_CE_NS   = 1000000000;
  localparam int T_SUS_NS  = 20000;
  localparam int T_DP_NS   = 3000;
  localparam int T_RES_NS  = 200;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_BUSY      = 3'h1,
    ST_SUSP_WAIT = 3'h2,
    ST_SUSPENDED = 3'h3,
    ST_PD_WAIT   = 3'h4,
    ST_PD        = 3'h5
  } sfp_state_t;
  typedef enum logic [2:0] {
    OPK_NONE = 3'h0,
    OPK_PP   = 3'h1,
    OPK_SE   = 3'h2,
    OPK_B32  = 3'h3,
    OPK_B64  = 3'h4,
    OPK_CE   = 3'h5
  } sfp_op_t;
endpackage : sfp_pkg

//--- rtl/sfp_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: quad program takes address, up to 256 bytes
// RULE_02: quad program needs quad enable and latch
// RULE_03: sector erase clears addressed 4K sector
// RULE_04: small block erase clears 32K block
// RULE_05: large block erase clears 64K block
// RULE_06: two opcodes both mean chip erase
// RULE_07: erase ignored while write latch clear
// RULE_08: frame must end on byte boundary
// RULE_09: busy high during cycle, low after
// RULE_10: cycle end clears write latch
// RULE_11: protected targets are never programmed or erased
// RULE_12: any protection refuses chip erase
// RULE_13: suspend only during busy non-chip operation
// RULE_14: erase suspended blocks erases, status writes
// RULE_15: program suspended blocks programs, status writes
// RULE_16: suspend flag now, busy drops within latency
// RULE_17: host spaces suspend after resume
// RULE_18: resume only suspended idle, busy returns
// RULE_19: reset leaves no suspend state
// RULE_20: power-down entered after entry time
// RULE_21: powered down hears only release opcode
// RULE_22: reset always lands in normal operation
// RULE_23: page data wraps within 256 bytes
// RULE_24: all durations are timing parameters
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int PP_NS  = T_PP_NS,
  parameter int SE_NS  = T_SE_NS,
  parameter int B32_NS = T_B32_NS,
  parameter int B64_NS = T_B64_NS,
  parameter int CE_NS  = T_CE_NS,
  parameter int SUS_NS = T_SUS_NS,
  parameter int DP_NS  = T_DP_NS
) (
  // system clock and control
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  // serial link
  input  wire logic        link_clk_in,
  input  wire logic        link_cs_n_in,
  input  wire logic [3:0]  link_io_in,
  // configuration and protection
  input  wire logic        quad_enable_in,
  input  wire logic        quad_command_mode_in,
  input  wire logic        wel_set_in,
  input  wire logic        target_protected_in,
  input  wire logic        any_protected_in,
  // status
  output logic             busy_out,
  output logic             write_enable_latch_out,
  output logic             suspend_flag_out,
  output logic             powered_down_out,
  output logic             status_read_enable_out,
  output logic             status_write_block_out,
  output logic [23:0]      cmd_addr_out,
  // array operation report
  output logic             op_done_out,
  output logic [2:0]       op_kind_out,
  output logic [23:0]      op_addr_out,
  output logic [8:0]       pgm_len_out,
  output logic             release_out,
  // page buffer read
  input  wire logic [7:0]  pgm_idx_in,
  output logic [7:0]       pgm_byte_out
);
  // operation durations rounded up; suspend latency is a maximum and power-down entry too, so both rounded down
  localparam int PP_CYC  = (PP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SE_CYC  = (SE_NS + CLK_NS - 1) / CLK_NS;
  localparam int B32_CYC = (B32_NS + CLK_NS - 1) / CLK_NS;
  localparam int B64_CYC = (B64_NS + CLK_NS - 1) / CLK_NS;
  localparam int CE_CYC  = (CE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUS_CYC = (SUS_NS / CLK_NS < 1) ? 1 : SUS_NS / CLK_NS;
  localparam int DP_CYC  = (DP_NS / CLK_NS < 1) ? 1 : DP_NS / CLK_NS;
  localparam int RES_CYC = T_RES_NS / CLK_NS;

  function automatic sfp_op_t op_kind(input logic [7:0] op);
    case (op)
      OP_QPP:         op_kind = OPK_PP;
      OP_SE:          op_kind = OPK_SE;
      OP_B32:         op_kind = OPK_B32;
      OP_B64:         op_kind = OPK_B64;
      // RULE_06 two chip opcodes
      OP_CE1, OP_CE2: op_kind = OPK_CE;
      default:        op_kind = OPK_NONE;
    endcase
  endfunction : op_kind

  function automatic logic frame_fits(input logic [7:0] op,
                                      input logic [2:0] n);
    case (op_kind(op))
      OPK_PP:                   frame_fits = (n == DATA_MIN);
      OPK_SE, OPK_B32, OPK_B64: frame_fits = (n == HDR_BYTES);
      default:                  frame_fits = (n == ONE_BYTE);
    endcase
  endfunction : frame_fits

  // ------------------------------------------------------------
  // link domain: byte assembly
  // ------------------------------------------------------------
  logic        lk_fresh;
  logic        lk_qpi_meta;
  logic        lk_qpi;
  logic [2:0]  lk_bits;
  logic [2:0]  lk_bytes;
  logic [7:0]  lk_shift;
  logic [7:0]  lk_op;
  logic [23:0] lk_addr;
  logic [8:0]  lk_len;
  logic [7:0]  lk_widx;
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [2:0]  cur_bits;
  logic [2:0]  cur_bytes;
  logic [8:0]  cur_len;
  logic        wide;
  logic        lk_wr;
  logic [2:0]  next_bits;
  logic [2:0]  next_bytes;
  logic [7:0]  next_shift;
  logic [7:0]  next_op;
  logic [23:0] next_addr;
  logic [8:0]  next_len;
  logic [7:0]  next_widx;

  // chip select high marks the next edge as a frame start
  always_ff @(posedge link_clk_in or posedge link_cs_n_in) begin
    if (link_cs_n_in) begin
      lk_fresh <= 1'b1;
    end else begin
      lk_fresh <= 1'b0;
    end
  end

  // shift one bit, or a nibble in quad phases
  always_comb begin
    cur_bits   = lk_fresh ? 3'h0 : lk_bits;
    cur_bytes  = lk_fresh ? 3'h0 : lk_bytes;
    cur_len    = lk_fresh ? 9'h000 : lk_len;
    // RULE_01 quad data phase
    wide       = lk_qpi || (cur_bytes >= HDR_BYTES && lk_op == OP_QPP);
    next_shift = wide ? {lk_shift[3:0], link_io_in}
                      : {lk_shift[6:0], link_io_in[0]};
    next_bits  = cur_bits + (wide ? 3'h4 : 3'h1);
    next_bytes = cur_bytes;
    next_op    = lk_op;
    next_addr  = lk_addr;
    next_len   = cur_len;
    next_widx  = lk_widx;
    lk_wr      = 1'b0;
    if (next_bits == 3'h0) begin
      if (cur_bytes != DATA_MIN) begin
        next_bytes = cur_bytes + 3'h1;
      end
      if (cur_bytes == 3'h0) begin
        next_op = next_shift;
      end else if (cur_bytes < HDR_BYTES) begin
        next_addr = {lk_addr[15:0], next_shift};
        next_widx = next_shift;
      end else begin
        // RULE_23 index wraps in page
        lk_wr     = 1'b1;
        next_widx = lk_widx + 8'h01;
        if (cur_len != LEN_MAX) begin
          next_len = cur_len + 9'h001;
        end
      end
    end
  end

  // link registers hold still once the clock stops after a frame
  always_ff @(posedge link_clk_in) begin
    lk_qpi_meta <= quad_command_mode_in;
    lk_qpi      <= lk_qpi_meta;
    lk_bits     <= next_bits;
    lk_bytes    <= next_bytes;
    lk_shift    <= next_shift;
    lk_op       <= next_op;
    lk_addr     <= next_addr;
    lk_len      <= next_len;
    lk_widx     <= next_widx;
    if (lk_wr) begin
      page_buf[lk_widx] <= next_shift;
    end
  end

  // ------------------------------------------------------------
  // system domain: frame capture
  // ------------------------------------------------------------
  logic        cs_meta;
  logic        cs_sync;
  logic        cs_prev;
  logic        fr_meta;
  logic        fr_sync;
  logic        clk_seen;
  logic        frame_vld;
  logic        cmd_ok;
  logic [7:0]  cmd_op;
  logic [2:0]  cmd_bytes;
  logic [8:0]  cmd_len;
  logic        next_frame;

  // captured only after synced chip select rises: link data is static
  always_comb begin
    next_frame = cs_sync && !cs_prev;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cs_meta      <= 1'b1;
      cs_sync      <= 1'b1;
      cs_prev      <= 1'b1;
      fr_meta      <= 1'b1;
      fr_sync      <= 1'b1;
      clk_seen     <= 1'b0;
      frame_vld    <= 1'b0;
      cmd_ok       <= 1'b0;
      cmd_op       <= 8'h00;
      cmd_bytes    <= 3'h0;
      cmd_len      <= 9'h000;
      cmd_addr_out <= 24'h000000;
      pgm_byte_out <= 8'h00;
    end else if (ce_in) begin
      cs_meta      <= link_cs_n_in;
      cs_sync      <= cs_meta;
      cs_prev      <= cs_sync;
      // start flag is set again by chip select, so keep a sticky copy
      fr_meta      <= lk_fresh;
      fr_sync      <= fr_meta;
      if (next_frame) begin
        clk_seen <= 1'b0;
      end else if (!fr_sync) begin
        clk_seen <= 1'b1;
      end
      frame_vld    <= next_frame;
      pgm_byte_out <= page_buf[pgm_idx_in];
      if (next_frame) begin
        // RULE_08 byte boundary check
        cmd_ok       <= clk_seen && lk_bits == 3'h0;
        cmd_op       <= lk_op;
        cmd_bytes    <= lk_bytes;
        cmd_len      <= lk_len;
        cmd_addr_out <= lk_addr;
      end
    end
  end

  // ------------------------------------------------------------
  // system domain: operation sequencer
  // ------------------------------------------------------------
  sfp_state_t  state;
  sfp_state_t  next_state;
  sfp_op_t     kind;
  sfp_op_t     run_kind;
  sfp_op_t     next_run_kind;
  logic [31:0] op_timer;
  logic [31:0] next_op_timer;
  logic [31:0] aux_timer;
  logic [31:0] next_aux_timer;
  logic        next_wel;
  logic        next_sus;
  logic        next_done;
  logic        next_release;
  logic [23:0] next_op_addr;
  logic [8:0]  next_pgm_len;
  logic        go;
  logic        arr_ok;

  always_comb begin
    kind   = op_kind(cmd_op);
    go     = frame_vld && cmd_ok && frame_fits(cmd_op, cmd_bytes);
    // RULE_07 latch required
    arr_ok = write_enable_latch_out && kind != OPK_NONE;
    // RULE_02 quad enable
    if (kind == OPK_PP && !quad_enable_in) begin
      arr_ok = 1'b0;
    end
    // RULE_11 RULE_12 protection gate
    if (kind == OPK_CE ? any_protected_in : target_protected_in) begin
      arr_ok = 1'b0;
    end
  end

  always_comb begin
    next_state     = state;
    next_run_kind  = run_kind;
    next_op_timer  = op_timer;
    next_aux_timer = aux_timer;
    next_sus       = suspend_flag_out;
    next_wel       = write_enable_latch_out;
    next_done      = 1'b0;
    next_release   = 1'b0;
    next_op_addr   = op_addr_out;
    next_pgm_len   = pgm_len_out;
    unique case (state)
      ST_IDLE: begin
        if (go && cmd_op == OP_PD) begin
          next_state     = ST_PD_WAIT;
          next_aux_timer = 32'(DP_CYC);
        end else if (go && arr_ok) begin
          next_state    = ST_BUSY;
          next_run_kind = kind;
          next_pgm_len  = cmd_len;
          // RULE_03 RULE_04 RULE_05 region alignment
          unique case (kind)
            OPK_PP: begin
              next_op_timer = 32'(PP_CYC);
              next_op_addr  = cmd_addr_out;
            end
            OPK_SE: begin
              next_op_timer = 32'(SE_CYC);
              next_op_addr  = cmd_addr_out & ~MASK_SE;
            end
            OPK_B32: begin
              next_op_timer = 32'(B32_CYC);
              next_op_addr  = cmd_addr_out & ~MASK_B32;
            end
            OPK_B64: begin
              next_op_timer = 32'(B64_CYC);
              next_op_addr  = cmd_addr_out & ~MASK_B64;
            end
            default: begin
              next_op_timer = 32'(CE_CYC);
              next_op_addr  = 24'h000000;
            end
          endcase
        end
      end
      ST_BUSY: begin
        // RULE_13 suspend acceptance
        if (go && cmd_op == OP_SUSP && run_kind != OPK_CE) begin
          // RULE_16 flag set at once
          next_sus       = 1'b1;
          next_state     = ST_SUSP_WAIT;
          next_aux_timer = 32'(SUS_CYC);
        end else if (op_timer <= 32'h1) begin
          // RULE_09 RULE_10 cycle completion
          next_state = ST_IDLE;
          next_done  = 1'b1;
          next_wel   = 1'b0;
        end else begin
          next_op_timer = op_timer - 32'h1;
        end
      end
      ST_SUSP_WAIT: begin
        if (aux_timer <= 32'h1) begin
          next_state = ST_SUSPENDED;
        end else begin
          next_aux_timer = aux_timer - 32'h1;
        end
      end
      ST_SUSPENDED: begin
        // RULE_14 RULE_15 only resume is heard
        if (go && cmd_op == OP_RES) begin
          // RULE_18 resume continues cycle with remaining timer
          next_sus   = 1'b0;
          next_state = ST_BUSY;
        end
      end
      ST_PD_WAIT: begin
        // RULE_20 entry delay
        if (aux_timer <= 32'h1) begin
          next_state = ST_PD;
        end else begin
          next_aux_timer = aux_timer - 32'h1;
        end
      end
      ST_PD: begin
        // RULE_21 release opcode only
        if (frame_vld && cmd_ok && cmd_op == OP_RPD) begin
          next_state   = ST_IDLE;
          next_release = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // set beats the end-of-cycle clear
    if (wel_set_in) begin
      next_wel = 1'b1;
    end
  end

  // RULE_19 RULE_22 reset lands idle, unsuspended
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state                  <= ST_IDLE;
      run_kind               <= OPK_NONE;
      op_timer               <= 32'h0;
      aux_timer              <= 32'h0;
      suspend_flag_out       <= 1'b0;
      write_enable_latch_out <= 1'b0;
      op_done_out            <= 1'b0;
      release_out            <= 1'b0;
      op_addr_out            <= 24'h000000;
      pgm_len_out            <= 9'h000;
    end else if (ce_in) begin
      state                  <= next_state;
      run_kind               <= next_run_kind;
      op_timer               <= next_op_timer;
      aux_timer              <= next_aux_timer;
      suspend_flag_out       <= next_sus;
      write_enable_latch_out <= next_wel;
      op_done_out            <= next_done;
      release_out            <= next_release;
      op_addr_out            <= next_op_addr;
      pgm_len_out            <= next_pgm_len;
    end
  end

  // status decoded straight from the state register; write block follows the suspend flag
  assign busy_out               = state == ST_BUSY || state == ST_SUSP_WAIT;
  assign powered_down_out       = state == ST_PD;
  assign status_read_enable_out = state != ST_PD;
  assign status_write_block_out = suspend_flag_out;
  assign op_kind_out            = run_kind;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  localparam int SUS_MAX = SUS_CYC;

  a_done_clears_wel: assert property (op_done_out && !$past(wel_set_in)
    |-> !write_enable_latch_out) else $error("latch kept after cycle"); // RULE_10
  a_done_not_busy: assert property (op_done_out |-> !busy_out
    && $past(busy_out)) else $error("busy wrong at completion"); // RULE_09
  a_wel_needed: assert property (state == ST_IDLE && ce_in && frame_vld
    && !write_enable_latch_out |=> state != ST_BUSY)
    else $error("array op without latch"); // RULE_07
  a_qe_needed: assert property (state == ST_IDLE && ce_in && go
    && kind == OPK_PP && !quad_enable_in |=> !busy_out)
    else $error("quad program without enable"); // RULE_02
  a_ce_protected: assert property (state == ST_IDLE && ce_in && go
    && kind == OPK_CE && any_protected_in |=> !busy_out)
    else $error("chip erase under protection"); // RULE_12
  a_unaligned_drop: assert property (state == ST_IDLE && ce_in
    && frame_vld && !cmd_ok |=> state == ST_IDLE)
    else $error("unaligned frame executed"); // RULE_08
  a_susp_flag: assert property (state == ST_BUSY && ce_in && go
    && cmd_op == OP_SUSP && run_kind != OPK_CE
    |=> suspend_flag_out && busy_out) else $error("suspend late"); // RULE_16
  a_susp_bound: assert property (state == ST_SUSP_WAIT
    |-> aux_timer <= 32'(SUS_MAX)) else $error("suspend too slow"); // RULE_16
  a_ce_no_susp: assert property (run_kind == OPK_CE && busy_out
    |-> !suspend_flag_out) else $error("chip erase suspended"); // RULE_13
  a_resume_busy: assert property (state == ST_SUSPENDED && ce_in && go
    && cmd_op == OP_RES |=> busy_out && !suspend_flag_out)
    else $error("resume not taken"); // RULE_18
  a_pd_quiet: assert property (powered_down_out
    |-> !status_read_enable_out && !busy_out)
    else $error("status live in power-down"); // RULE_21
  a_reset_clean: assert property ($past(srst_in) |-> !suspend_flag_out
    && !powered_down_out) else $error("bad state after reset"); // RULE_22
  initial begin
    assert (RES_CYC >= 1) else $error("resume bound below one cycle");
  end

  c_erase_done: cover property (op_done_out && run_kind == OPK_SE);
  c_susp_res: cover property (state == ST_SUSPENDED ##[1:1000] busy_out);
  c_pd_release: cover property (powered_down_out ##[1:1000] release_out);
  c_prog_done: cover property (op_done_out && run_kind == OPK_PP);

endmodule : sfp_ctrl

//--- tb/sfp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side of the serial link
// ----------------------------------------
module sfp_host_model
  import sfp_pkg::*;
(
  // serial link
  output logic       link_clk_out,
  output logic       link_cs_n_out,
  output logic [3:0] link_io_out
);
  // clock stands low and select high outside frames
  initial begin
    link_clk_out  = 1'b0;
    link_cs_n_out = 1'b1;
    link_io_out   = 4'h5;
  end
  // one frame; drop removes trailing edges to leave a partial byte
  task automatic xfer(input logic [7:0] b[$], input int drop);
    logic [3:0] q[$];
    int         k;
    for (int i = 0; i < b.size(); i++) begin
      if (b[0] == OP_QPP && i >= 4) begin
        q.push_back(b[i][7:4]);
        q.push_back(b[i][3:0]);
      end else begin
        for (int j = 7; j >= 0; j--) begin
          q.push_back({3'(q.size()), b[i][j]}); // upper lines toggle
        end
      end
    end
    repeat (drop) void'(q.pop_back());
    link_cs_n_out = 1'b0;
    for (k = 0; k < q.size(); k++) begin
      link_io_out = q[k];
      #62.5 link_clk_out = 1'b1;
      #62.5 link_clk_out = 1'b0;
    end
    #20 link_cs_n_out = 1'b1;
    // released lines: never leave the last value standing
    link_io_out = ~link_io_out;
  endtask : xfer
endmodule : sfp_host_model

//--- tb/serial_flash_program_erase_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %h got %h", nm, (e), (g)); end end
module serial_flash_program_erase_control_test
  import sfp_pkg::*;
;
  logic        sys_clk_in = 0, srst_in = 1, ce_in = 1, quad_command_mode = 0;
  logic        link_clk, link_cs_n, qe = 0, wset = 0, tprot = 0, aprot = 0;
  logic [3:0]  link_io;
  logic        busy, write_enable_latch, suspend_flag, pd, rden, swblk, done, rel;
  logic [2:0]  kind;
  logic [23:0] caddr, oaddr, a;
  logic [8:0]  plen;
  logic [7:0]  pidx = 0, pbyte, page[256], f[$];
  logic        m_busy = 0, m_sus = 0, m_wel = 0, m_pd = 0;
  sfp_op_t     m_kind = OPK_NONE;
  int          miscompares = 0, cmp_count = 0, cyc = 0, rel_seen = 0, t;
  integer      seed = 32'h817d5aa8;
  // ----------------------------------------
  // clocks, timeout, pulse watch
  // ----------------------------------------
  always #2 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc++;
    if (rel === 1'b1) rel_seen++;
    if (cyc == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  sfp_host_model host (.link_clk_out(link_clk), .link_cs_n_out(link_cs_n),
                       .link_io_out(link_io));
  // short durations keep the run small; erase long enough to suspend
  sfp_ctrl #(.PP_NS(800), .SE_NS(8000), .B32_NS(1200), .B64_NS(1400),
    .CE_NS(8000)) uut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .link_clk_in(link_clk), .link_cs_n_in(link_cs_n), .link_io_in(link_io),
    .quad_enable_in(qe), .quad_command_mode_in(quad_command_mode), .wel_set_in(wset),
    .target_protected_in(tprot), .any_protected_in(aprot),
    .busy_out(busy), .write_enable_latch_out(write_enable_latch), .suspend_flag_out(suspend_flag),
    .powered_down_out(pd), .status_read_enable_out(rden),
    .status_write_block_out(swblk), .cmd_addr_out(caddr),
    .op_done_out(done), .op_kind_out(kind), .op_addr_out(oaddr),
    .pgm_len_out(plen), .release_out(rel), .pgm_idx_in(pidx),
    .pgm_byte_out(pbyte));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic set_wel();
    @(negedge sys_clk_in) wset = 1'b1;
    @(negedge sys_clk_in) wset = 1'b0;
    m_wel = 1'b1;
  endtask : set_wel
  // model decides acceptance, then the frame goes out and status is compared
  task automatic cmd(input int drop);
    logic [7:0] op;
    int         n;
    op = f[0];
    n  = f.size();
    if (drop != 0) n = 0;
    if (m_pd) begin
      if (op == OP_RPD && n > 0) m_pd = 0;
    end else if (m_busy) begin
      if (op == OP_SUSP && n == 1 && m_kind != OPK_CE && !m_sus) m_sus = 1;
    end else if (m_sus) begin
      if (op == OP_RES && n == 1) {m_sus, m_busy} = 2'b01;
    end else if (m_wel && n == 4 && !tprot && op inside {OP_SE, OP_B32,
                 OP_B64}) begin
      m_busy = 1;
      m_kind = op == OP_SE ? OPK_SE : op == OP_B32 ? OPK_B32 : OPK_B64;
    end else if (m_wel && n == 1 && !aprot && op inside {OP_CE1, OP_CE2}) begin
      m_busy = 1;
      m_kind = OPK_CE;
    end else if (m_wel && n >= 5 && qe && !tprot && op == OP_QPP) begin
      m_busy = 1;
      m_kind = OPK_PP;
      for (int i = 4; i < n; i++) page[8'(f[3] + i - 4)] = f[i];
    end else if (n == 1 && op == OP_PD) m_pd = 1;
    host.xfer(f, drop);
    repeat (10) @(negedge sys_clk_in);
    `CHK("busy", m_busy, busy)
    `CHK("suspend", m_sus, suspend_flag)
    `CHK("latch", m_wel, write_enable_latch)
  endtask : cmd
  task automatic fin(input sfp_op_t k, input logic [23:0] ad);
    t = 0;
    while (done !== 1'b1 && t < 4000) begin
      @(negedge sys_clk_in);
      t++;
    end
    `CHK("done", 1'b1, done)
    `CHK("op_kind", k, kind)
    `CHK("op_addr", ad, oaddr)
    repeat (2) @(negedge sys_clk_in);
    {m_busy, m_wel} = 2'b00;
    `CHK("busy_end", m_busy, busy)
    `CHK("latch_end", m_wel, write_enable_latch)
  endtask : fin
  task automatic wait_for(ref logic s, input logic v);
    for (t = 0; t < 6000 && s !== v; t++) @(negedge sys_clk_in);
  endtask : wait_for
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk_in);
    srst_in = 1'b0;
    `CHK("pd_reset", 1'b0, pd)
    `CHK("rden_reset", 1'b1, rden)
    `CHK("sus_reset", 1'b0, suspend_flag)
    a = 24'($random(seed));
    f = {OP_SE, a[23:16], a[15:8], a[7:0]};
    cmd(0);
    set_wel();
    cmd(4);
    tprot = 1;
    cmd(0);
    {tprot, aprot} = 2'b01;
    f = {OP_CE2};
    cmd(0);
    aprot = 0;
    f = {OP_CE1, 8'h00};
    cmd(0);
    f = {OP_QPP, a[23:16], a[15:8], a[7:0], 8'h3c};
    cmd(0);
    // every erase opcode once, random target
    for (int i = 0; i < 5; i++) begin
      a = 24'($random(seed));
      set_wel();
      f = {OP_SE, a[23:16], a[15:8], a[7:0]};
      if (i == 1) f[0] = OP_B32;
      if (i == 2) f[0] = OP_B64;
      if (i > 2) f = {i == 3 ? OP_CE1 : OP_CE2};
      cmd(0);
      fin(m_kind, i == 0 ? a & ~MASK_SE : i == 1 ? a & ~MASK_B32 :
          i == 2 ? a & ~MASK_B64 : 24'h0);
    end
    // page program past the page end wraps
    qe = 1;
    set_wel();
    f = {OP_QPP, a[23:16], a[15:8], a[7:0]};
    repeat (260) f.push_back(8'($random(seed)));
    cmd(0);
    fin(OPK_PP, a);
    `CHK("pgm_len", LEN_MAX, plen)
    for (int j = 0; j < 256; j++) begin
      pidx = 8'(j);
      @(negedge sys_clk_in);
      `CHK("page", page[j], pbyte)
    end
    // suspend, refused work, resume; no suspend soon after a resume
    // suspend spacing kept
    set_wel();
    a = 24'($random(seed));
    f = {OP_SE, a[23:16], a[15:8], a[7:0]};
    cmd(0);
    f = {OP_SUSP};
    cmd(0);
    wait_for(busy, 1'b0);
    m_busy = 0;
    `CHK("busy_susp", 1'b0, busy)
    set_wel();
    f = {OP_B64, a[23:16], a[15:8], a[7:0]};
    cmd(0);
    f = {OP_QPP, a[23:16], a[15:8], a[7:0], 8'h5a};
    cmd(0);
    `CHK("sr_block", 1'b1, swblk)
    f = {OP_RES};
    cmd(0);
    fin(OPK_SE, a & ~MASK_SE);
    cmd(0);
    f = {OP_SUSP};
    cmd(0);
    set_wel();
    f = {OP_CE2};
    cmd(0);
    f = {OP_SUSP};
    cmd(0);
    fin(OPK_CE, 24'h0);
    // reset while suspended
    set_wel();
    f = {OP_SE, a[23:16], a[15:8], a[7:0]};
    cmd(0);
    f = {OP_SUSP};
    cmd(0);
    repeat (5100) @(negedge sys_clk_in);
    `CHK("sus_before_reset", 1'b1, suspend_flag)
    srst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    srst_in = 1'b0;
    {m_busy, m_sus, m_wel} = 3'b000;
    f = {OP_RES};
    cmd(0);
    // power-down and release
    f = {OP_PD};
    cmd(0);
    wait_for(pd, 1'b1);
    `CHK("pd_on", 1'b1, pd)
    `CHK("rden_pd", 1'b0, rden)
    set_wel();
    f = {OP_SE, a[23:16], a[15:8], a[7:0]};
    cmd(0);
    f = {OP_RPD};
    rel_seen = 0;
    cmd(0);
    `CHK("pd_off", 1'b0, pd)
    `CHK("release", 1, rel_seen)
    stop_test();
  end
endmodule : serial_flash_program_erase_control_test
